// ==== pkg/rsd_pkg.sv ====
// Constants for the reset source and start-up delay sequencer.
// Assumes a 50 MHz system clock and an AXI4-Lite register port.
package rsd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Register byte offsets
  localparam logic [3:0] OFS_CFG    = 4'h0;
  localparam logic [3:0] OFS_CAUSE  = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // Configuration field positions and values after reset
  localparam int unsigned CFG_SEL_LSB   = 0;
  localparam int unsigned CFG_RANGE_BIT = 3;
  localparam int unsigned CFG_BOOT_BIT  = 4;
  localparam logic [2:0]  SEL_RST_VAL   = 3'h2;
  // Cause flag positions
  localparam int unsigned CAUSE_POR_BIT = 0;
  localparam int unsigned CAUSE_PIN_BIT = 1;
  localparam int unsigned CAUSE_WDT_BIT = 3;
  // Vectors
  localparam logic [12:0] VEC_RESET_LOW  = 13'h0000;
  localparam logic [12:0] VEC_RESET_BOOT = 13'h1e00;
  localparam logic [12:0] VEC_IRQ_BASE   = 13'h0002;
  // Real-time part in watchdog oscillator cycles
  localparam int unsigned WDT_SHORT_NORM = 1024;
  localparam int unsigned WDT_LONG_NORM  = 16384;
  localparam int unsigned WDT_SHORT_RNG  = 4096;
  localparam int unsigned WDT_LONG_RNG   = 65536;
  // Minimal real-time delay and power-up extension, in their own units
  localparam int unsigned T_MIN_NS     = 30000;
  localparam int unsigned T_POWERUP_NS = 600000;
  localparam int unsigned MIN_CYC =
    (T_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_CYC =
    (T_POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // System clock part
  localparam int unsigned CK_SHORT = 6;
  localparam int unsigned CK_MID   = 1024;
  localparam int unsigned CK_LONG  = 16384;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {
    ST_HOLD, ST_PWR, ST_RT, ST_CK, ST_RUN, ST_WAKE
  } rsd_state_e;
endpackage : rsd_pkg

// ==== rtl/rsd_sync.sv ====
// Two-flop level synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module rsd_sync #(
  parameter int unsigned W      = 1,
  parameter logic [W-1:0] RST_V = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_r[g] <= RST_V[g];
          o_q[g]    <= RST_V[g];
        end else begin
          meta_r[g] <= i_d[g];
          o_q[g]    <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule : rsd_sync

// ==== rtl/rsd_seq.sv ====
// Reset source combiner and start-up delay sequencer with register port.
// Assumes pin, supply detector and watchdog oscillator are asynchronous;
// the watchdog expiry, its enable and the wake request are on i_clk.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Reset core from supply, pin or watchdog
// - Pin low over 500 ns resets clocklessly
// - After reset, fetch starts at 0
// - Boot fuse moves reset vector to 1e00
// - Select code picks short, long, minimal delay
// - Select code adds 6, 16K or 1K clocks
// - Real-time counts 1K/16K or 4K/64K oscillator
// - Wake from sleep counts only clocks
// - Real-time part timed by watchdog oscillator; the minimal delay counts i_clk instead
// - Power-up adds about 0.6 ms
// - Supply rise starts delay counter
// - Supply fall reasserts reset at once
// - Pin release starts delay timer
// - Watchdog resets only when enabled
// - Select defaults to code 010
// - Watchdog pulse one clock, count after
// - Cause flags; write zero clears them
module rsd_seq
  import rsd_pkg::*;
#(
  parameter int unsigned WDT_SHORT_N  = WDT_SHORT_NORM,
  parameter int unsigned WDT_LONG_N   = WDT_LONG_NORM,
  parameter int unsigned WDT_SHORT_R  = WDT_SHORT_RNG,
  parameter int unsigned WDT_LONG_R   = WDT_LONG_RNG,
  parameter int unsigned POWERUP_N    = POWERUP_CYC,
  parameter int unsigned CK_LONG_N    = CK_LONG
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_pin_rst_b,
  input  wire logic        i_supply_ok,
  input  wire logic        i_wdt_osc,
  input  wire logic        i_wdt_expire,
  input  wire logic        i_wdt_en,
  input  wire logic        i_wake_req,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             o_core_rst_b,
  output logic             o_core_run,
  output logic [12:0]      o_reset_vector,
  output logic [12:0]      o_irq_vector_base
);
  logic [2:0]  sync_q;
  logic        pin_low_s, supply_low_s, osc_s;
  logic        seq_arst_b, wdt_rst, src_any;
  // Pin and supply clear the sequencer without a clock edge
  assign seq_arst_b = i_rst_b & i_pin_rst_b & i_supply_ok;

  rsd_sync #(.W(3), .RST_V(3'h7)) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     ({i_wdt_osc, i_supply_ok, i_pin_rst_b}),
    .o_q     (sync_q)
  );
  assign pin_low_s    = ~sync_q[0];
  assign supply_low_s = ~sync_q[1];
  assign osc_s        = sync_q[2];

  assign wdt_rst = i_wdt_expire & i_wdt_en;
  assign src_any = wdt_rst | pin_low_s | supply_low_s;

  // Register file, fuse image and cause flags
  logic [2:0]  sel_r, sel_nxt;
  logic        rng_r, rng_nxt;
  logic        boot_r, boot_nxt;
  logic        f_por_r, f_por_nxt;
  logic        f_pin_r, f_pin_nxt;
  logic        f_wdt_r, f_wdt_nxt;
  logic        pwr_pend_r, pwr_pend_nxt;
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [3:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic        w_lane0_r, w_lane0_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  rsd_state_e  st_r, st_nxt;
  logic        wr_fire;
  logic [7:0]  cause_v;

  assign cause_v = {4'h0, f_wdt_r, 1'b0, f_pin_r, f_por_r};
  assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;

  always_comb begin
    sel_nxt      = sel_r;
    rng_nxt      = rng_r;
    boot_nxt     = boot_r;
    f_por_nxt    = f_por_r;
    f_pin_nxt    = f_pin_r;
    f_wdt_nxt    = f_wdt_r;
    pwr_pend_nxt = pwr_pend_r;
    aw_hold_nxt  = aw_hold_r;
    w_hold_nxt   = w_hold_r;
    aw_addr_nxt  = aw_addr_r;
    w_data_nxt   = w_data_r;
    w_lane0_nxt  = w_lane0_r;
    bvalid_nxt   = bvalid_r;
    bresp_nxt    = bresp_r;
    rvalid_nxt   = rvalid_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    if (s_axi_awvalid && !aw_hold_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r) begin
      w_hold_nxt  = 1'b1;
      w_data_nxt  = s_axi_wdata;
      w_lane0_nxt = s_axi_wstrb[0];
    end
    // Write zero clears a flag; only the low byte holds fields
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      case (aw_addr_r)
        OFS_CFG: begin
          if (w_lane0_r) begin
            sel_nxt  = w_data_r[CFG_SEL_LSB +: 3];
            rng_nxt  = w_data_r[CFG_RANGE_BIT];
            boot_nxt = w_data_r[CFG_BOOT_BIT];
          end
        end
        OFS_CAUSE: begin
          if (w_lane0_r) begin
            f_por_nxt = f_por_r & w_data_r[CAUSE_POR_BIT];
            f_pin_nxt = f_pin_r & w_data_r[CAUSE_PIN_BIT];
            f_wdt_nxt = f_wdt_r & w_data_r[CAUSE_WDT_BIT];
          end
        end
        OFS_STATUS: bresp_nxt = RESP_OKAY;
        default:    bresp_nxt = RESP_DECERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CFG:    rdata_nxt = {27'h0, boot_r, rng_r, sel_r};
        OFS_CAUSE:  rdata_nxt = {24'h0, cause_v};
        OFS_STATUS: rdata_nxt = {27'h0, o_core_run, o_core_rst_b,
                                 3'(st_r)};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_DECERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // Hardware sets win over a clearing write in the same cycle
    if (supply_low_s) begin
      f_por_nxt    = 1'b1;
      f_pin_nxt    = 1'b0;
      f_wdt_nxt    = 1'b0;
      pwr_pend_nxt = 1'b1;
    end else begin
      if (pin_low_s) f_pin_nxt = 1'b1;
      if (wdt_rst)   f_wdt_nxt = 1'b1;
      if (st_r == ST_CK) pwr_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_r      <= SEL_RST_VAL;
      rng_r      <= 1'b0;
      boot_r     <= 1'b0;
      f_por_r    <= 1'b1;
      f_pin_r    <= 1'b0;
      f_wdt_r    <= 1'b0;
      pwr_pend_r <= 1'b1;
      aw_hold_r  <= 1'b0;
      w_hold_r   <= 1'b0;
      aw_addr_r  <= 4'h0;
      w_data_r   <= 32'h0000_0000;
      w_lane0_r  <= 1'b0;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= RESP_OKAY;
    end else begin
      sel_r      <= sel_nxt;
      rng_r      <= rng_nxt;
      boot_r     <= boot_nxt;
      f_por_r    <= f_por_nxt;
      f_pin_r    <= f_pin_nxt;
      f_wdt_r    <= f_wdt_nxt;
      pwr_pend_r <= pwr_pend_nxt;
      aw_hold_r  <= aw_hold_nxt;
      w_hold_r   <= w_hold_nxt;
      aw_addr_r  <= aw_addr_nxt;
      w_data_r   <= w_data_nxt;
      w_lane0_r  <= w_lane0_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  assign s_axi_awready = ~aw_hold_r;
  assign s_axi_wready  = ~w_hold_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Delay targets from the select code
  logic        rt_min, rt_long;
  logic [16:0] rt_target;
  logic [15:0] ck_target;
  always_comb begin
    rt_min  = (sel_r == 3'h1) || (sel_r == 3'h4) || (sel_r == 3'h7);
    rt_long = (sel_r == 3'h2) || (sel_r == 3'h5);
    if (rng_r) begin
      rt_target = rt_long ? 17'(WDT_LONG_R) : 17'(WDT_SHORT_R);
    end else begin
      rt_target = rt_long ? 17'(WDT_LONG_N) : 17'(WDT_SHORT_N);
    end
    if (rt_min) begin
      rt_target = 17'(MIN_CYC);
    end
    if (sel_r <= 3'h1) begin
      ck_target = 16'(CK_SHORT);
    end else if (sel_r <= 3'h4) begin
      ck_target = 16'(CK_LONG_N);
    end else begin
      ck_target = 16'(CK_MID);
    end
  end

  // Sequencer: cleared asynchronously by pin or supply
  logic [16:0] cnt_r, cnt_nxt;
  logic        osc_d_r, osc_d_nxt;
  logic        rst_b_nxt, run_nxt, osc_rise;
  logic [12:0] vec_nxt;
  assign osc_rise = osc_s & ~osc_d_r;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    osc_d_nxt = osc_s;
    case (st_r)
      ST_HOLD: begin
        cnt_nxt = 17'h0_0000;
        if (!src_any) begin
          st_nxt = pwr_pend_r ? ST_PWR : ST_RT;
        end
      end
      ST_PWR: begin
        cnt_nxt = cnt_r + 17'h0_0001;
        if (cnt_r + 17'h0_0001 >= 17'(POWERUP_N)) begin
          st_nxt  = ST_RT;
          cnt_nxt = 17'h0_0000;
        end
      end
      ST_RT: begin
        // Minimal delay is clock-timed; others count oscillator edges
        if (rt_min || osc_rise) begin
          cnt_nxt = cnt_r + 17'h0_0001;
        end
        if ((rt_min || osc_rise) && cnt_r + 17'h0_0001 >= rt_target) begin
          st_nxt  = ST_CK;
          cnt_nxt = 17'h0_0000;
        end
      end
      ST_CK, ST_WAKE: begin
        cnt_nxt = cnt_r + 17'h0_0001;
        if (cnt_r + 17'h0_0001 >= {1'b0, ck_target}) begin
          st_nxt  = ST_RUN;
          cnt_nxt = 17'h0_0000;
        end
      end
      ST_RUN: begin
        if (i_wake_req) begin
          st_nxt  = ST_WAKE;
          cnt_nxt = 17'h0_0000;
        end
      end
      default: st_nxt = ST_HOLD;
    endcase
    if (src_any) begin
      st_nxt  = ST_HOLD;
      cnt_nxt = 17'h0_0000;
    end
    rst_b_nxt = (st_nxt == ST_RUN) || (st_nxt == ST_WAKE);
    run_nxt   = (st_nxt == ST_RUN);
    vec_nxt   = boot_r ? VEC_RESET_BOOT : VEC_RESET_LOW;
  end

  always_ff @(posedge i_clk or negedge seq_arst_b) begin
    if (!seq_arst_b) begin
      st_r              <= ST_HOLD;
      cnt_r             <= 17'h0_0000;
      osc_d_r           <= 1'b0;
      o_core_rst_b      <= 1'b0;
      o_core_run        <= 1'b0;
      o_reset_vector    <= VEC_RESET_LOW;
      o_irq_vector_base <= VEC_IRQ_BASE;
    end else begin
      st_r              <= st_nxt;
      cnt_r             <= cnt_nxt;
      osc_d_r           <= osc_d_nxt;
      o_core_rst_b      <= rst_b_nxt;
      o_core_run        <= run_nxt;
      o_reset_vector    <= vec_nxt;
      o_irq_vector_base <= VEC_IRQ_BASE;
    end
  end
endmodule : rsd_seq

// ==== verif/rsd_seq_properties.sv ====
// Checker for the reset sequencer outputs.
// Assumes it is bound to rsd_seq and sees only its ports.
`timescale 1ns/1ps
module rsd_props
  import rsd_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_pin_rst_b,
  input wire logic        i_supply_ok,
  input wire logic        i_wdt_expire,
  input wire logic        i_wdt_en,
  input wire logic        i_wake_req,
  input wire logic        o_core_rst_b,
  input wire logic        o_core_run,
  input wire logic [12:0] o_irq_vector_base
);
  wire hit = i_wdt_expire & i_wdt_en;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  pin_low_a: assert property (!i_pin_rst_b |-> !o_core_rst_b)
    else $error("core out of reset with pin low");
  supply_low_a: assert property (!i_supply_ok |-> !o_core_rst_b)
    else $error("core out of reset with supply low");
  wdt_rst_a: assert property (hit |-> ##[1:2] !o_core_rst_b)
    else $error("watchdog expiry gave no reset");
  // An expiry while disabled must leave a running core alone
  wdt_off_a: assert property (o_core_rst_b && !hit && !$past(hit)
    |=> o_core_rst_b || !i_pin_rst_b || !i_supply_ok)
    else $error("reset without an enabled source");
  pin_hold_a: assert property ($rose(i_pin_rst_b)
    |-> !o_core_rst_b [*6])
    else $error("reset released too soon after pin");
  run_rst_a: assert property (o_core_run |-> o_core_rst_b)
    else $error("core runs while held in reset");
  irq_base_a: assert property (o_core_rst_b
    |-> o_irq_vector_base == VEC_IRQ_BASE)
    else $error("interrupt vectors moved");
  wake_cnt_a: assert property (o_core_run && i_wake_req && !hit
    && i_pin_rst_b && i_supply_ok |-> ##[1:2] (o_core_rst_b && !o_core_run))
    else $error("wake did not hold core in clock count");
endmodule : rsd_props
bind rsd_seq rsd_props i_props (.i_clk, .i_rst_b, .i_pin_rst_b,
  .i_supply_ok, .i_wdt_expire, .i_wdt_en, .i_wake_req, .o_core_rst_b,
  .o_core_run, .o_irq_vector_base);

// ==== verif/rsd_partner.sv ====
// Model of the reset pin driver, supply detector and watchdog oscillator.
// Assumes the bench calls its tasks; the oscillator runs free.
`timescale 1ns/1ps
module rsd_partner (
  output logic o_pin_rst_b,
  output logic o_supply_ok,
  output logic o_wdt_osc
);
  initial begin
    o_pin_rst_b = 1'b1;
    o_supply_ok = 1'b0;
    o_wdt_osc   = 1'b0;
    #7;
    forever #80 o_wdt_osc = ~o_wdt_osc;
  end
  // Caller keeps the low time above 500 ns; shorter ones may be lost
  task automatic pin_pulse(input int unsigned ns);
    o_pin_rst_b = 1'b0;
    #(ns);
    o_pin_rst_b = 1'b1;
  endtask : pin_pulse
  task automatic supply_set(input logic up);
    o_supply_ok = up;
  endtask : supply_set
endmodule : rsd_partner

// ==== verif/reset_source_startup_delay_tb_top.sv ====
// Self-checking bench for the reset sequencer.
// Assumes rsd_seq, its checker and the partner model are compiled first.
`timescale 1ns/1ps
module reset_source_startup_delay_tb_top
  import rsd_pkg::*;
;
  localparam int SH_N = 4, LG_N = 8, SH_R = 6, LG_R = 10;
  localparam int PWR_N = 20, CKL_N = 30, OSC = 8;
  logic        i_clk, i_rst_b, wdt_expire, wdt_en, wake_req;
  logic        awvalid, wvalid, arvalid, bready, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, seed;
  logic [2:0]  code;
  wire         awready, wready, bvalid, arready, rvalid, rst_b, run;
  wire         pin_b, sup, osc;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [12:0] rvec, irqb;
  logic [33:0] rd_q[$];
  logic [12:0] vec_q[$];
  int          cyc_q[$];
  logic [1:0]  b_q[$];
  int          cnt, bad_count, num_checks;
  rsd_partner i_partner (.o_pin_rst_b(pin_b), .o_supply_ok(sup),
    .o_wdt_osc(osc));
  rsd_seq #(.WDT_SHORT_N(SH_N), .WDT_LONG_N(LG_N), .WDT_SHORT_R(SH_R),
    .WDT_LONG_R(LG_R), .POWERUP_N(PWR_N), .CK_LONG_N(CKL_N)) i_dut (
    .i_clk, .i_rst_b, .i_pin_rst_b(pin_b), .i_supply_ok(sup),
    .i_wdt_osc(osc), .i_wdt_expire(wdt_expire), .i_wdt_en(wdt_en),
    .i_wake_req(wake_req), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .o_core_rst_b(rst_b), .o_core_run(run), .o_reset_vector(rvec),
    .o_irq_vector_base(irqb));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Clocks from last source release to run; the wdt edge slack is allowed in the check
  function automatic int exp_cyc(input logic [2:0] c, input logic r,
                                 input logic p, input logic w);
    int rt;
    int ck;
    rt = (c == 1 || c == 4 || c == 7) ? MIN_CYC :
         (c == 2 || c == 5) ? (r ? LG_R : LG_N) * OSC :
         (r ? SH_R : SH_N) * OSC;
    ck = (c < 2) ? CK_SHORT : (c < 5) ? CKL_N : CK_MID;
    return (w ? 0 : rt) + ck + (p ? PWR_N : 0);
  endfunction : exp_cyc
  task automatic fail(input string m);
    bad_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic stop;
    fail("wait timed out");
    print_verdict();
  endtask : stop
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    b_q.push_back((a == OFS_CFG || a == OFS_CAUSE || a == OFS_STATUS) ?
                  RESP_OKAY : RESP_DECERR);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 100);
    if (n >= 100) stop();
    // One idle edge so a following call never re-raises bready at once
    bready <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rd_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 100);
    if (n >= 100) stop();
    rready <= 1'b0;
    @(posedge i_clk);
  endtask : rd
  task automatic expect_run(input logic [12:0] v, input int c);
    vec_q.push_back(v);
    cyc_q.push_back(c);
  endtask : expect_run
  task automatic wait_run;
    int n;
    n = 0;
    while (run && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    while (!run && n < 4000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 4000) stop();
  endtask : wait_run
  task automatic pulse;
    seed = lfsr(seed);
    i_partner.pin_pulse(510 + seed[7:0]);
    @(posedge i_clk);
  endtask : pulse
  task automatic kick;
    wdt_expire <= 1'b1;
    @(posedge i_clk);
    wdt_expire <= 1'b0;
    @(posedge i_clk);
  endtask : kick
  always @(posedge i_clk) begin
    if (!pin_b || !sup || (wdt_expire && wdt_en)) cnt <= 0;
    else if (run) cnt <= 0;
    else cnt <= cnt + 1;
    if (rvalid) begin
      num_checks++;
      if (rd_q.size() == 0) fail("unexpected read data");
      else if ({rresp, rdata} !== rd_q.pop_front()) fail("read mismatch");
    end
    if (bvalid) begin
      num_checks++;
      if (b_q.size() == 0) fail("unexpected write response");
      else if (bresp !== b_q.pop_front()) fail("write response");
    end
    if ($rose(run)) begin
      num_checks++;
      if (vec_q.size() == 0) fail("unexpected core start");
      else if (rvec !== vec_q.pop_front()) fail("reset vector");
      else if (cnt + 8 < cyc_q[0] || cnt > cyc_q[0] + 10)
        fail("start-up delay length");
      if (cyc_q.size() > 0) void'(cyc_q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    fail("run too long");
    print_verdict();
  end
  initial begin
    {i_rst_b, awvalid, wvalid, arvalid, bready, rready} = '0;
    {wdt_expire, wdt_en, awaddr, araddr, wdata, wake_req, code} = '0;
    wstrb = 4'hf;
    seed = 32'ha4ed;
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    rd(OFS_CFG, {RESP_OKAY, 32'h0000_0002});
    rd(OFS_CAUSE, {RESP_OKAY, 32'h0000_0001});
    rd(4'hc, {RESP_DECERR, 32'h0000_0000});
    expect_run(VEC_RESET_LOW, exp_cyc(3'h2, 1'b0, 1'b1, 1'b0));
    i_partner.supply_set(1'b1);
    wait_run();
    wr(OFS_CAUSE, 32'h0000_0000);
    // Low lane off: the fields must keep their values
    wstrb <= 4'he;
    wr(OFS_CFG, 32'h0000_001f);
    wstrb <= 4'hf;
    rd(OFS_CFG, {RESP_OKAY, 32'h0000_0002});
    wr(4'hc, 32'h0000_001f);
    for (int c = 0; c < 8; c++) begin
      code = c[2:0];
      wr(OFS_CFG, {27'h0, code[0], code[1], code});
      expect_run(code[0] ? VEC_RESET_BOOT : VEC_RESET_LOW,
                 exp_cyc(code, code[1], 1'b0, 1'b0));
      pulse();
      repeat (8 + seed[2:0]) @(posedge i_clk);
      pulse();
      wait_run();
    end
    rd(OFS_CAUSE, {RESP_OKAY, 32'h0000_0002});
    expect_run(VEC_RESET_BOOT, exp_cyc(code, 1'b1, 1'b0, 1'b1));
    wake_req <= 1'b1;
    @(posedge i_clk);
    wake_req <= 1'b0;
    wait_run();
    wr(OFS_CAUSE, 32'h0000_0000);
    wdt_en <= 1'b1;
    expect_run(VEC_RESET_BOOT, exp_cyc(code, 1'b1, 1'b0, 1'b0));
    kick();
    wait_run();
    rd(OFS_CAUSE, {RESP_OKAY, 32'h0000_0008});
    wdt_en <= 1'b0;
    kick();
    repeat (20) @(posedge i_clk);
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_001c});
    expect_run(VEC_RESET_BOOT, exp_cyc(code, 1'b1, 1'b1, 1'b0));
    i_partner.supply_set(1'b0);
    repeat (5) @(posedge i_clk);
    i_partner.supply_set(1'b1);
    wait_run();
    rd(OFS_CAUSE, {RESP_OKAY, 32'h0000_0001});
    print_verdict();
  end
endmodule : reset_source_startup_delay_tb_top
